// ==== src/fwsr_host.sv ====
// flash write-status host: runs command sequences and status polling
// assumes an apb master on pclk and one byte-wide flash on the pins
// Contract
// R1: device pulls ready/busy low while programming or erasing, else releases.
// R2: device ready/busy is open-drain; only pulls low.
// R3: device status valid from the last write strobe of a sequence.
// R4: device inverts toggle bit one on each read while an algorithm runs.
// R5: all selected sectors protected: toggle bit one toggles about 100 us.
// R6: program into protected sector: toggle bit one toggles about 2 us.
// R7: device erases unprotected selected sectors, skips protected ones.
// R8: toggle bit one toggles during erase, stops in erase suspend.
// R9: toggle bit one toggles during erase-suspend program until it completes.
// R10: toggle bit two toggles on reads in erasing sectors, not programs.
// R11: host polls at the programmed or a selected sector address.
// R12: host rereads the polling bit after seeing the timeout bit set.
// R13: device sets the timeout bit when the pulse limit is exceeded.
// R14: programming a 1 over a 0 halts and sets the timeout bit.
// R15: after a timeout failure host issues the reset command.
// R16: erase-window bit 0 during acceptance timeout, 1 after; restarted per command.
// R17: host ignores erase-window bit only with additions under 50 us apart.
// R18: device takes more sector erases while window 0; then only suspend.
// R19: host confirms acceptance, checks erase-window bit before and after additions.
// R20: toggle polling starts with two reads compared; equal means done.
// R21: still toggling with timeout set: compare again; toggling means failed, reset.
// R22: interrupted toggle monitoring restarts from its first two reads.
// R23: polling bit shows complement while programming, 0 while erasing.
// R24: suspended device gives array data from non-suspended sectors.
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/10ps
module fwsr_host (
   // clock and reset
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   // apb slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [7:0]                  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   // flash pins
   output logic      [fwsr_pkg::ADDR_W-1:0] flash_addr,
   output logic                             flash_ce_n,
   output logic                             flash_oe_n,
   output logic                             flash_we_n,
   output logic      [fwsr_pkg::DATA_W-1:0] data_lines_o,
   output logic                             data_lines_oe,
   input  wire logic [fwsr_pkg::DATA_W-1:0] data_lines_i,
   input  wire logic                        ready_busy_output
);
   import fwsr_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SEQ   = 2'b01,
      ST_POLL  = 2'b10,
      ST_RESET = 2'b11
   } fwsr_state_t;

   fwsr_state_t       st_q, st_d;
   fwsr_op_t          op_q, op_d;
   logic [2:0]        step_q, step_d;
   logic [1:0]        ph_q, ph_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [DATA_W-1:0] data_q, data_d, prev_q, prev_d, last_q, last_d;
   logic [31:0]       prdata_q, prdata_d;
   logic issued_q, issued_d, done_q, done_d, fail_q, fail_d, acc_q, acc_d;
   logic win_q, win_d, rej_q, rej_d, mrej_q, mrej_d, rb1_q, rb2_q;
   logic              cyc_req, cyc_wr, cyc_done, wr_en, go, mapped, toggled;
   logic [ADDR_W-1:0] cyc_addr, seq_addr;
   logic [DATA_W-1:0] cyc_wdata, seq_data, rd;

   fwsr_bus_cycle u_cycle (
      .pclk          (pclk),
      .presetn       (presetn),
      .req           (cyc_req),
      .wr            (cyc_wr),
      .addr          (cyc_addr),
      .wdata         (cyc_wdata),
      .done          (cyc_done),
      .rdata         (rd),
      .flash_addr    (flash_addr),
      .flash_ce_n    (flash_ce_n),
      .flash_oe_n    (flash_oe_n),
      .flash_we_n    (flash_we_n),
      .data_lines_o  (data_lines_o),
      .data_lines_oe (data_lines_oe),
      .data_lines_i  (data_lines_i)
   );

   // unlock and command words per sequence step
   always_comb begin
      seq_addr = UNLOCK_ADDR_A;
      seq_data = UNLOCK_DATA_A;
      case (step_q)
         3'h1, 3'h4: begin
            seq_addr = UNLOCK_ADDR_B;
            seq_data = UNLOCK_DATA_B;
         end
         3'h2: seq_data = (op_q == OP_PROGRAM) ? CMD_PROGRAM : CMD_ERASE_SETUP;
         3'h3: begin
            if (op_q == OP_PROGRAM) begin
               seq_addr = addr_q;
               seq_data = data_q;
            end
         end
         3'h5: begin
            seq_addr = addr_q;
            seq_data = CMD_SECTOR_ERASE;
         end
         default: ;
      endcase
   end

   assign cyc_wr    = (st_q != ST_POLL);
   assign cyc_addr  = (st_q == ST_SEQ) ? seq_addr : addr_q;  // R11
   assign cyc_wdata = (st_q == ST_RESET) ? CMD_RESET : seq_data;
   assign toggled   = rd[TOGGLE_ONE_BIT] ^ prev_q[TOGGLE_ONE_BIT];
   assign wr_en     = psel && penable && pwrite;
   assign mapped    = (paddr == REG_CTRL) || (paddr == REG_ADDR) ||
                      (paddr == REG_DATA) || (paddr == REG_STATUS);
   assign go        = wr_en && (paddr == REG_CTRL) && pwdata[CTRL_GO_BIT] && (st_q == ST_IDLE);

   always_comb begin
      st_d     = st_q;
      op_d     = op_q;
      step_d   = step_q;
      ph_d     = ph_q;
      addr_d   = addr_q;
      data_d   = data_q;
      prev_d   = prev_q;
      last_d   = last_q;
      prdata_d = prdata_q;
      issued_d = issued_q;
      done_d   = done_q;
      fail_d   = fail_q;
      acc_d    = acc_q;
      win_d    = win_q;
      rej_d    = rej_q;
      mrej_d   = mrej_q;
      cyc_req  = 1'b0;
      // read data is loaded in the setup phase so it comes from a flop
      if (psel && !penable) begin
         case (paddr)
            REG_CTRL:   prdata_d = {29'h0000_0000, op_q};
            REG_ADDR:   prdata_d = {12'h000, addr_q};
            REG_DATA:   prdata_d = {24'h00_0000, data_q};
            REG_STATUS: prdata_d = {16'h0000, last_q, rb2_q, mrej_q, rej_q, win_q, acc_q,
                                    fail_q, done_q, (st_q != ST_IDLE)};
            default:    prdata_d = 32'h0000_0000;
         endcase
      end
      // operands are frozen while an operation runs
      if (wr_en && st_q == ST_IDLE && paddr == REG_ADDR) begin
         addr_d = pwdata[ADDR_W-1:0];
      end
      if (wr_en && st_q == ST_IDLE && paddr == REG_DATA) begin
         data_d = pwdata[DATA_W-1:0];
      end
      if (go) begin
         op_d   = fwsr_op_t'(pwdata[CTRL_OP_LSB +: 3]);
         done_d = 1'b0;
         fail_d = 1'b0;
         acc_d  = 1'b0;
         rej_d  = 1'b0;
         mrej_d = 1'b0;
         ph_d   = 2'h0;
         step_d = (op_d == OP_SECTOR_ADD) ? STEP_ERASE_LAST : 3'h0;
         case (op_d)
            OP_READ, OP_WAIT, OP_SECTOR_ADD: st_d = ST_POLL;  // R22
            OP_PROGRAM, OP_SECTOR_ERASE:     st_d = ST_SEQ;
            OP_RESET:                        st_d = ST_RESET;
            default:                         done_d = 1'b1;
         endcase
      end
      if (st_q != ST_IDLE && !issued_q) begin
         cyc_req  = 1'b1;
         issued_d = 1'b1;
      end
      if (cyc_done) begin
         issued_d = 1'b0;
         case (st_q)
            ST_SEQ: begin
               if (step_q == ((op_q == OP_PROGRAM) ? STEP_PROG_LAST : STEP_ERASE_LAST)) begin
                  st_d = ST_POLL;
                  ph_d = (op_q == OP_SECTOR_ADD) ? 2'h1 : 2'h0;
               end else begin
                  step_d = step_q + 3'h1;
               end
            end
            ST_POLL: begin
               last_d = rd;
               prev_d = rd;
               st_d   = ST_IDLE;
               done_d = 1'b1;
               case (op_q)
                  OP_PROGRAM: begin
                     if (rd[POLLING_BIT] != data_q[POLLING_BIT]) begin
                        if (ph_q == 2'h1) begin
                           st_d   = ST_RESET;  // R15
                           fail_d = 1'b1;
                        end else begin
                           st_d = ST_POLL;
                           ph_d = rd[TIMEOUT_BIT] ? 2'h1 : 2'h0;  // R12
                        end
                        done_d = 1'b0;
                     end
                  end
                  OP_WAIT: begin
                     if (!ph_q[0] || toggled) begin
                        st_d   = ST_POLL;
                        done_d = 1'b0;
                        ph_d   = ph_q + 2'h1;  // R20
                        if (ph_q == 2'h1) begin
                           ph_d = rd[TIMEOUT_BIT] ? 2'h2 : 2'h0;  // R21 R22
                        end else if (ph_q == 2'h3) begin
                           st_d   = ST_RESET;  // R21 R15
                           fail_d = 1'b1;
                        end
                     end
                  end
                  OP_SECTOR_ERASE: begin
                     if (ph_q == 2'h0) begin
                        st_d   = ST_POLL;
                        done_d = 1'b0;
                        ph_d   = 2'h1;
                     end else begin
                        acc_d = toggled;  // R19
                        win_d = rd[ERASE_WINDOW_BIT];
                     end
                  end
                  OP_SECTOR_ADD: begin
                     win_d = rd[ERASE_WINDOW_BIT];  // R17
                     if (ph_q == 2'h0) begin
                        if (rd[ERASE_WINDOW_BIT]) begin
                           rej_d = 1'b1;  // R19
                        end else begin
                           st_d   = ST_SEQ;
                           done_d = 1'b0;
                        end
                     end else begin
                        mrej_d = rd[ERASE_WINDOW_BIT];  // R19
                     end
                  end
                  default: ;
               endcase
            end
            ST_RESET: begin
               st_d   = ST_IDLE;
               done_d = 1'b1;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q     <= ST_IDLE;
         op_q     <= OP_READ;
         step_q   <= 3'h0;
         ph_q     <= 2'h0;
         addr_q   <= '0;
         data_q   <= '0;
         prev_q   <= '0;
         last_q   <= '0;
         prdata_q <= 32'h0000_0000;
         issued_q <= 1'b0;
         done_q   <= 1'b0;
         fail_q   <= 1'b0;
         acc_q    <= 1'b0;
         win_q    <= 1'b0;
         rej_q    <= 1'b0;
         mrej_q   <= 1'b0;
         rb1_q    <= 1'b0;
         rb2_q    <= 1'b0;
      end else begin
         st_q     <= st_d;
         op_q     <= op_d;
         step_q   <= step_d;
         ph_q     <= ph_d;
         addr_q   <= addr_d;
         data_q   <= data_d;
         prev_q   <= prev_d;
         last_q   <= last_d;
         prdata_q <= prdata_d;
         issued_q <= issued_d;
         done_q   <= done_d;
         fail_q   <= fail_d;
         acc_q    <= acc_d;
         win_q    <= win_d;
         rej_q    <= rej_d;
         mrej_q   <= mrej_d;
         // low on the shared pulled-up wire means busy
         rb1_q    <= ready_busy_output;
         rb2_q    <= rb1_q;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_poll_read;
      st_q == ST_POLL && cyc_done;
   endsequence
   sequence s_fail_entry;
      st_q == ST_POLL && st_d == ST_RESET;
   endsequence

   chk_poll_address: assert property ($fell(flash_oe_n) |-> flash_addr == addr_q) // R11
      else $error("status read not at the polled address");
   chk_program_recheck: assert property (s_fail_entry and op_q == OP_PROGRAM // R12
      |-> ph_q == 2'h1 && rd[POLLING_BIT] != data_q[POLLING_BIT])
      else $error("program failure declared without a polling recheck");
   chk_reset_follows: assert property (s_fail_entry |=> cyc_req && cyc_wr // R15
      && cyc_wdata == CMD_RESET ##1 !done_q[*4])
      else $error("failure not followed by the reset command");
   chk_add_gated: assert property (st_q == ST_SEQ && op_q == OP_SECTOR_ADD // R17
      |-> !win_q && ph_q == 2'h0)
      else $error("sector erase addition issued with window closed");
   chk_after_check: assert property (s_poll_read and op_q == OP_SECTOR_ADD and ph_q == 2'h1 // R19
      |=> mrej_q == rd[ERASE_WINDOW_BIT] && done_q)
      else $error("erase window not checked after addition");
   chk_toggle_pass: assert property (s_poll_read and op_q == OP_WAIT and st_d == ST_IDLE // R20
      |-> ph_q[0] && !toggled)
      else $error("toggle wait ended without two equal reads");
   chk_toggle_fail: assert property (s_fail_entry and op_q == OP_WAIT // R21
      |-> ph_q == 2'h3 && toggled)
      else $error("toggle failure without a second comparison");
   chk_toggle_restart: assert property (s_poll_read and op_q == OP_WAIT and ph_q == 2'h1 // R22
      and toggled and !rd[TIMEOUT_BIT] |=> ph_q == 2'h0 ##1 !cyc_done)
      else $error("toggle monitoring did not restart from its first read");
endmodule

// ==== common/fwsr_pkg.sv ====
// constants shared by the flash status host and its bus cycle engine
// assumes a 200 MHz pclk and a byte-wide flash with strobe-timed pins
package fwsr_pkg;
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned SYNC_STAGES   = 2;
   localparam int unsigned T_READ_NS     = 100;
   localparam int unsigned T_WRITE_NS    = 50;
   localparam int unsigned T_RECOVER_NS  = 30;
   // least times round up; reads also cover the pin synchroniser
   localparam int unsigned READ_CYC      = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
                                           + SYNC_STAGES;
   localparam int unsigned WRITE_CYC     = (T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RECOVER_CYC   = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int unsigned ADDR_W = 20;
   localparam int unsigned DATA_W = 8;

   // register map, byte addresses on apb
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_DATA   = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam int unsigned CTRL_OP_LSB = 0;
   localparam int unsigned CTRL_GO_BIT = 8;
   localparam int unsigned ST_BUSY_BIT   = 0;
   localparam int unsigned ST_DONE_BIT   = 1;
   localparam int unsigned ST_FAIL_BIT   = 2;
   localparam int unsigned ST_ACC_BIT    = 3;
   localparam int unsigned ST_WIN_BIT    = 4;
   localparam int unsigned ST_REJ_BIT    = 5;
   localparam int unsigned ST_MREJ_BIT   = 6;
   localparam int unsigned ST_READY_BIT  = 7;
   localparam int unsigned ST_RDATA_LSB  = 8;

   // status bit positions on the data lines
   localparam int unsigned POLLING_BIT      = 7;
   localparam int unsigned TOGGLE_ONE_BIT   = 6;
   localparam int unsigned TIMEOUT_BIT      = 5;
   localparam int unsigned ERASE_WINDOW_BIT = 3;

   // flash command words
   localparam logic [19:0] UNLOCK_ADDR_A    = 20'h0_0555;
   localparam logic [19:0] UNLOCK_ADDR_B    = 20'h0_02AA;
   localparam logic [7:0]  UNLOCK_DATA_A    = 8'hAA;
   localparam logic [7:0]  UNLOCK_DATA_B    = 8'h55;
   localparam logic [7:0]  CMD_PROGRAM      = 8'hA0;
   localparam logic [7:0]  CMD_ERASE_SETUP  = 8'h80;
   localparam logic [7:0]  CMD_SECTOR_ERASE = 8'h30;
   localparam logic [7:0]  CMD_RESET        = 8'hF0;
   localparam logic [2:0]  STEP_PROG_LAST   = 3'h3;
   localparam logic [2:0]  STEP_ERASE_LAST  = 3'h5;

   typedef enum logic [2:0] {
      OP_READ         = 3'b000,
      OP_PROGRAM      = 3'b001,
      OP_SECTOR_ERASE = 3'b010,
      OP_SECTOR_ADD   = 3'b011,
      OP_WAIT         = 3'b100,
      OP_RESET        = 3'b101
   } fwsr_op_t;
endpackage

// ==== src/fwsr_bus_cycle.sv ====
// one read or write cycle on the flash pins per request
// captures wr, addr and wdata with req when idle, so the caller need not hold them until done
`timescale 1ns/10ps
module fwsr_bus_cycle #(
   parameter int unsigned READ_CYCLES    = fwsr_pkg::READ_CYC,
   parameter int unsigned WRITE_CYCLES   = fwsr_pkg::WRITE_CYC,
   parameter int unsigned RECOVER_CYCLES = fwsr_pkg::RECOVER_CYC
) (
   // clock and reset
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   // request side
   input  wire logic                        req,
   input  wire logic                        wr,
   input  wire logic [fwsr_pkg::ADDR_W-1:0] addr,
   input  wire logic [fwsr_pkg::DATA_W-1:0] wdata,
   output logic                             done,
   output logic      [fwsr_pkg::DATA_W-1:0] rdata,
   // flash pins
   output logic      [fwsr_pkg::ADDR_W-1:0] flash_addr,
   output logic                             flash_ce_n,
   output logic                             flash_oe_n,
   output logic                             flash_we_n,
   output logic      [fwsr_pkg::DATA_W-1:0] data_lines_o,
   output logic                             data_lines_oe,
   input  wire logic [fwsr_pkg::DATA_W-1:0] data_lines_i
);
   import fwsr_pkg::*;

   if (READ_CYCLES < SYNC_STAGES + 1 || READ_CYCLES > 255 || WRITE_CYCLES < 1 ||
       WRITE_CYCLES > 255 || RECOVER_CYCLES < 1 || RECOVER_CYCLES > 255) begin : g_bad
      $error("fwsr_bus_cycle: cycle counts out of range");
   end

   typedef enum logic [1:0] {
      BC_IDLE  = 2'b00,
      BC_SETUP = 2'b01,
      BC_PULSE = 2'b10,
      BC_HOLD  = 2'b11
   } fwsr_bc_t;

   fwsr_bc_t          bst_q, bst_d;
   logic [7:0]        cnt_q, cnt_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [DATA_W-1:0] wd_q, wd_d, rd_q, rd_d, sync1_q, sync2_q;
   logic              ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d;
   logic              oe_q, oe_d, wr_q, wr_d, done_q, done_d;

   always_comb begin
      bst_d  = bst_q;
      cnt_d  = cnt_q;
      addr_d = addr_q;
      wd_d   = wd_q;
      rd_d   = rd_q;
      ce_n_d = ce_n_q;
      oe_n_d = oe_n_q;
      we_n_d = we_n_q;
      oe_d   = oe_q;
      wr_d   = wr_q;
      done_d = 1'b0;
      case (bst_q)
         BC_IDLE: begin
            if (req) begin
               bst_d  = BC_SETUP;
               addr_d = addr;
               wd_d   = wdata;
               wr_d   = wr;
               ce_n_d = 1'b0;
               oe_d   = wr;
            end
         end
         BC_SETUP: begin
            bst_d  = BC_PULSE;
            oe_n_d = wr_q;
            we_n_d = !wr_q;
            cnt_d  = wr_q ? WRITE_CYCLES[7:0] : READ_CYCLES[7:0];
         end
         BC_PULSE: begin
            cnt_d = cnt_q - 8'h01;
            if (cnt_q == 8'h01) begin
               bst_d  = BC_HOLD;
               oe_n_d = 1'b1;
               we_n_d = 1'b1;
               cnt_d  = RECOVER_CYCLES[7:0];
               // synchronised copy of the data lines at strobe end
               if (!wr_q) begin
                  rd_d = sync2_q;
               end
            end
         end
         default: begin
            // chip select rises a cycle after the strobe so the write edge still sees it low
            ce_n_d = 1'b1;
            cnt_d  = cnt_q - 8'h01;
            if (cnt_q == 8'h01) begin
               bst_d  = BC_IDLE;
               oe_d   = 1'b0;
               done_d = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bst_q   <= BC_IDLE;
         cnt_q   <= 8'h00;
         addr_q  <= '0;
         wd_q    <= '0;
         rd_q    <= '0;
         ce_n_q  <= 1'b1;
         oe_n_q  <= 1'b1;
         we_n_q  <= 1'b1;
         oe_q    <= 1'b0;
         wr_q    <= 1'b0;
         done_q  <= 1'b0;
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         bst_q   <= bst_d;
         cnt_q   <= cnt_d;
         addr_q  <= addr_d;
         wd_q    <= wd_d;
         rd_q    <= rd_d;
         ce_n_q  <= ce_n_d;
         oe_n_q  <= oe_n_d;
         we_n_q  <= we_n_d;
         oe_q    <= oe_d;
         wr_q    <= wr_d;
         done_q  <= done_d;
         sync1_q <= data_lines_i;
         sync2_q <= sync1_q;
      end
   end

   assign done          = done_q;
   assign rdata         = rd_q;
   assign flash_addr    = addr_q;
   assign flash_ce_n    = ce_n_q;
   assign flash_oe_n    = oe_n_q;
   assign flash_we_n    = we_n_q;
   assign data_lines_o  = wd_q;
   assign data_lines_oe = oe_q;

   chk_strobe_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
      !(!oe_n_q && (!we_n_q || oe_q)))
      else $error("read strobe overlaps a write or driven data lines");
endmodule

// ==== bench/fwsr_flash_model.sv ====
// behavioural byte flash: write status bits on reads, commands on we_n
// assumes the host strobes reads with oe_n and writes with we_n
`timescale 1ns/10ps
module fwsr_flash_model #(
   parameter int         BUSY_N  = 5,
   parameter int         ERASE_N = 12,
   parameter int         WIN_N   = 4,
   parameter logic [3:0] PROT    = 4'hF
) (
   // pins
   input  wire logic [19:0] a,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [7:0]  din,
   output logic      [7:0]  dq,
   output logic             rb_low
);
   logic [7:0] mem [int];
   logic [7:0] q    = 8'h00;
   logic [7:0] pd   = 8'h00;
   logic [3:0] sect = 4'h0;
   logic drv = 0, pend = 0, e80 = 0, ers = 0, fail = 0, t1 = 0, t2 = 0;
   int busy = 0, wcnt = 0;
   assign rb_low = busy > 0;
   // released lines show the inverse so stale data never passes
   assign dq = drv ? q : ~q;
   function automatic logic [7:0] rd(input int k);
      return mem.exists(k) ? mem[k] : 8'hFF;
   endfunction
   always @(posedge we_n) if (!ce_n) begin
      if (din == 8'hF0) begin
         busy = 0;
         fail = 0;
         ers = 0;
      end else if (pend) begin
         pend = 0;
         pd = din;
         busy = (a[19:16] == PROT) ? 2 : BUSY_N;
         if ((din & ~rd(a)) != 0) fail = 1;
         else if (a[19:16] != PROT) mem[a] = din;
      end else if (din == 8'hA0) pend = 1;
      else if (din == 8'h80) e80 = 1;
      else if (din == 8'h30 && (e80 || (ers && wcnt > 0))) begin
         e80 = 0;
         ers = 1;
         sect = a[19:16];
         wcnt = WIN_N;
         busy = ERASE_N;
      end
   end
   always @(negedge oe_n) if (!ce_n) begin
      if (busy > 0) begin
         q = {ers ? 1'b0 : ~pd[7], t1, fail, 1'b0, wcnt == 0,
              (ers && a[19:16] == sect) ? t2 : 1'b0, 2'b00};
         t1 = ~t1;
         if (ers && a[19:16] == sect) t2 = ~t2;
         if (wcnt > 0) wcnt--;
         if (!fail) busy--;
         if (busy == 0 && ers) begin
            foreach (mem[k]) if ((k >> 16) == sect && sect != PROT) mem[k] = 8'hFF;
            ers = 0;
         end
      end else q = rd(a);
      drv = 1;
   end
   always @(posedge oe_n) drv = 0;
endmodule

// ==== bench/fwsr_host_tb.sv ====
// self-checking bench for the flash status host over apb
// assumes the behavioural flash model on the pins, pull-up on ready/busy
`timescale 1ns/10ps
module fwsr_host_tb;
   import fwsr_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr  = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rdat, r;
   logic pready, pslverr, perr, ce_n, oe_n, we_n, doe, rb_low;
   logic [19:0] fa, a, a0;
   logic [7:0]  dout, din, d;
   logic [31:0] seed = 32'h0000_7846;
   logic [7:0]  exp_mem [int];
   int err_count = 0, tests_run = 0, cyc = 0;
   always #2.5 pclk = ~pclk;
   fwsr_host uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .flash_addr(fa), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
      .flash_we_n(we_n), .data_lines_o(dout), .data_lines_oe(doe), .data_lines_i(din),
      .ready_busy_output(!rb_low));
   fwsr_flash_model dev (.a(fa), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .din(dout),
      .dq(din), .rb_low(rb_low));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      perr = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic op(input logic [2:0] o, input logic [19:0] fad, input logic [7:0] fd);
      apb(1, REG_ADDR, {12'h000, fad});
      apb(1, REG_DATA, {24'h00_0000, fd});
      apb(1, REG_CTRL, 32'h0000_0100 | o);
      do apb(0, REG_STATUS, 32'h0000_0000); while (rdat[ST_DONE_BIT] !== 1'b1);
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         err_count++;
         close_out();
      end
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1;
      // let the ready/busy synchroniser fill before the first status read
      repeat (2) @(posedge pclk);
      apb(0, REG_STATUS, 32'h0000_0000);
      chk("status_idle", 32'h0000_0080, rdat & 32'h0000_00FF);
      apb(0, 8'h10, 32'h0000_0000);
      chk("unmapped", 1, perr);
      for (int i = 0; i < 4; i++) begin
         r = xs();
         a = (i == 3) ? 20'hF_0123 : {4'h2 + i[3:0], r[15:0]};
         d = r[23:16];
         if (i == 0) a0 = a;
         if (a[19:16] != 4'hF) exp_mem[a] = d;
         op(OP_PROGRAM, a, d);
         // protected byte reads back erased; a cleared top bit then times out
         chk("prog_fail", (a[19:16] == 4'hF) && !d[7], rdat[ST_FAIL_BIT]);
         op(OP_READ, a, 8'h00);
         chk("prog_read", exp_mem.exists(a) ? exp_mem[a] : 8'hFF, rdat[15:8]);
      end
      op(OP_PROGRAM, 20'h5_0010, 8'h00);
      op(OP_PROGRAM, 20'h5_0010, 8'h0F);
      chk("fail_flag", 1, rdat[ST_FAIL_BIT]);
      chk("ready_after", 1, rdat[ST_READY_BIT]);
      op(OP_READ, 20'h5_0010, 8'h00);
      chk("fail_read", 0, rdat[15:8]);
      op(OP_SECTOR_ERASE, 20'h2_0000, 8'h00);
      chk("accepted", 1, rdat[ST_ACC_BIT]);
      op(OP_SECTOR_ADD, 20'h2_0000, 8'h00);
      chk("add_taken", 0, rdat[ST_MREJ_BIT:ST_REJ_BIT]);
      op(OP_WAIT, 20'h2_0000, 8'h00);
      chk("wait_ok", 0, rdat[ST_FAIL_BIT]);
      op(OP_READ, a0, 8'h00);
      chk("erased", 8'hFF, rdat[15:8]);
      op(OP_SECTOR_ADD, 20'h2_0000, 8'h00);
      chk("late_add", 1, rdat[ST_REJ_BIT]);
      close_out();
   end
endmodule
